// ### oldiag_top.sv
/*
  Openload diagnostics for four high-side outputs: on-state current check,
  LED low-current check and timed off-state test, with latched flags.
  Assumes synchronous inputs from the analog comparators and an Avalon-MM
  master that holds each request until waitrequest is seen low.
*/
`timescale 1ns/100ps

// What this block does
// RULE1: on-state openload check runs automatically whenever a channel output is on.
// RULE2: on-state openload sets quick flag, global openload flag and channel on-state bit.
// RULE3: latched on-state flag clears only after condition gone and channel status read.
// RULE4: detected on-state openload never switches the output off.
// RULE5: deglitch select picks 64 us when 0, 2.0 ms when 1.
// RULE6: deglitch counter runs only while output high, cleared when output low.
// RULE7: LED enable bit picks current check (0) or LED low-current check (1).
// RULE8: LED mode tests at turn-off; flags if still high after 2.0 ms or turn-on.
// RULE9: under PWM, LED evaluation starts each on-time end, lasts at most 2.0 ms.
// RULE10: LED test current stops at a no-fault result or after 2.0 ms.
// RULE11: trigger bit starts LED test at full duty; current ends 100 us after reactivation.
// RULE12: LED trigger bit clears itself when the triggered detection completes.
// RULE13: full-duty LED window lasts nominally 2.0 ms, at most 2.6 ms.
// RULE14: latched LED result clears on a read of that channel status.
// RULE15: off-test enable resets to 0; writing 1 starts test; no restart or abort.
// RULE16: enabled off-state tests start together on chip-select rising edge.
// RULE17: off-state test switches channel on with fixed test current threshold.
// RULE18: threshold reached ends test silently; timeout ends test and latches off-state flag.
// RULE19: off-state timeout nominally 1.2 ms, between 0.9 and 1.5 ms.
// RULE20: off-state test leaves overcurrent profile, current feedback and sense sync unchanged.
// RULE21: off-state openload sets quick, global and channel bits; channel read clears it.
// RULE22: overtemperature, undervoltage or pump fault aborts test, outputs off after deglitch.
// RULE23: quick flag is OR of overcurrent, overtemperature and both openload flags.
// RULE24: global openload flag clears only once every openload flag is cleared.
// RULE25: all intervals are clock counters; only the long deglitch, LED window and off-state timeout have parameterised terminal counts.
module oldiag_top #(
  parameter logic [15:0] ON_DGL_LONG_CYC = oldiag_pkg::ON_DGL_LONG_CYC_DEF,
  parameter logic [15:0] LED_WIN_CYC     = oldiag_pkg::LED_WIN_CYC_DEF,
  parameter logic [15:0] OFF_TIMEOUT_CYC = oldiag_pkg::OFF_TIMEOUT_CYC_DEF
) (
  input  wire logic                          clk_i,
  input  wire logic                          rst_n_i,
  input  wire logic [oldiag_pkg::ADDR_W-1:0] avs_address_i,
  input  wire logic                          avs_read_i,
  input  wire logic                          avs_write_i,
  input  wire logic [31:0]                   avs_writedata_i,
  input  wire logic [3:0]                    avs_byteenable_i,
  output logic      [31:0]                   avs_readdata_o,
  output logic                               avs_waitrequest_o,
  input  wire logic [oldiag_pkg::NCH-1:0]    out_on_cmd_i,
  input  wire logic [oldiag_pkg::NCH-1:0]    on_current_low_i,
  input  wire logic [oldiag_pkg::NCH-1:0]    led_out_high_i,
  input  wire logic [oldiag_pkg::NCH-1:0]    off_test_current_reached_i,
  input  wire logic [oldiag_pkg::NCH-1:0]    ch_other_fault_i,
  input  wire logic [oldiag_pkg::NCH-1:0]    overtemp_shutdown_i,
  input  wire logic                          undervoltage_fault_i,
  input  wire logic                          charge_pump_fault_i,
  input  wire logic                          spi_chip_select_n_i,
  output logic      [oldiag_pkg::NCH-1:0]    out_drive_o,
  output logic      [oldiag_pkg::NCH-1:0]    led_test_current_o,
  output logic      [oldiag_pkg::NCH-1:0]    off_test_current_limit_o,
  output logic      [oldiag_pkg::NCH-1:0]    channel_quick_flag_o,
  output logic                               global_openload_flag_o
);
  import oldiag_pkg::*;

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  logic                 wait_q;
  logic [31:0]          rdata_q;
  logic [31:0]          rd_val;
  logic [NCH-1:0]       dgl_sel_q;
  logic [NCH-1:0]       led_en_q;
  logic                 trig_q;
  logic [NCH-1:0]       trig_seen_q;
  logic [NCH-1:0]       on_ol_q;
  logic [NCH-1:0]       off_ol_q;
  logic [NCH-1:0]       out_drive_q;
  logic [NCH-1:0]       led_cur_q;
  logic [NCH-1:0]       off_lim_q;
  logic [NCH-1:0]       quick_q;
  logic                 global_q;
  logic                 csb_q;
  logic [NCH-1:0]       fault_sd_q;
  logic [NCH-1:0]       led_trig_ch_q;
  oldiag_led_st_t       led_st_q [NCH];
  oldiag_off_st_t       off_st_q [NCH];
  logic [CNT_W-1:0]     on_cnt_q [NCH];
  logic [CNT_W-1:0]     led_cnt_q [NCH];
  logic [CNT_W-1:0]     off_cnt_q [NCH];
  logic [CNT_W-1:0]     flt_cnt_q [NCH];
  logic [NCH-1:0]       drive_d;
  logic [NCH-1:0]       trig_hold;
  logic [NCH-1:0]       off_run;
  logic [NCH-1:0]       std_cond;
  logic [NCH-1:0]       std_set;
  logic [NCH-1:0]       led_set;
  logic [NCH-1:0]       off_set;
  logic [NCH-1:0]       rd_ch;
  logic [NCH-1:0]       clr_on;
  logic [NCH-1:0]       clr_off;
  logic [NCH-1:0]       trig_done;
  logic                 acc_done;
  logic                 wr_done;
  logic                 csb_rise;
  logic [NCH-1:0]       rd_hit;

  // one-hot channel status select from a byte address
  function automatic logic [NCH-1:0] ch_sel(input logic [ADDR_W-1:0] addr);
    logic [NCH-1:0] hit;
    hit = '0;
    for (int c = 0; c < NCH; c++) begin
      hit[c] = (addr == ADDR_CH_BASE + 5'(c) * ADDR_CH_STEP);
    end
    return hit;
  endfunction

  // terminal count of the on-state deglitch filter
  function automatic logic [CNT_W-1:0] dgl_limit(input logic sel);
    return sel ? ON_DGL_LONG_CYC : ON_DGL_SHORT_CYC; // RULE5 RULE25
  endfunction

  assign acc_done = (avs_read_i | avs_write_i) & ~wait_q;
  assign wr_done  = avs_write_i & ~wait_q;
  assign csb_rise = spi_chip_select_n_i & ~csb_q;

  // ------------------------------------------------------------------
  // register port
  // ------------------------------------------------------------------
  always_comb begin
    rd_val = '0;
    rd_hit = ch_sel(avs_address_i);
    case (avs_address_i)
      ADDR_CTRL:     rd_val = {23'h0, trig_q, led_en_q, dgl_sel_q};
      ADDR_OFF_TEST: rd_val = {28'h0, off_run | (off_st_q[0] == OFF_ARMED ? 4'h1 : 4'h0)
                               | (off_st_q[1] == OFF_ARMED ? 4'h2 : 4'h0)
                               | (off_st_q[2] == OFF_ARMED ? 4'h4 : 4'h0)
                               | (off_st_q[3] == OFF_ARMED ? 4'h8 : 4'h0)};
      ADDR_QUICK:    rd_val = {23'h0, global_q, 4'h0, quick_q};
      default: begin
        for (int c = 0; c < NCH; c++) begin
          if (rd_hit[c]) begin
            rd_val = {23'h0, global_q, 6'h0, on_ol_q[c], off_ol_q[c]};
          end
        end
      end
    endcase
  end

  // answer one cycle after the request is seen, then one cycle low
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wait_q  <= 1'b1;
      rdata_q <= '0;
    end else if ((avs_read_i | avs_write_i) & wait_q) begin
      wait_q  <= 1'b0;
      rdata_q <= avs_read_i ? rd_val : '0;
    end else begin
      wait_q  <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dgl_sel_q <= DGL_SEL_RST;
      led_en_q  <= LED_EN_RST;
    end else if (wr_done && avs_address_i == ADDR_CTRL && avs_byteenable_i[0]) begin
      dgl_sel_q <= avs_writedata_i[CTRL_DGL_LSB +: NCH];
      led_en_q  <= avs_writedata_i[CTRL_LED_LSB +: NCH]; // RULE7
    end
  end

  // bits actually returned by the read are the ones cleared
  always_comb begin
    rd_ch   = (acc_done & avs_read_i) ? ch_sel(avs_address_i) : '0;
    clr_off = rd_ch & {NCH{rdata_q[CH_OFF_BIT]}}; // RULE21
    clr_on  = rd_ch & {NCH{rdata_q[CH_ON_BIT]}} & (led_en_q | ~on_current_low_i); // RULE3 RULE14
  end

  // ------------------------------------------------------------------
  // output drive and fault shutdown
  // ------------------------------------------------------------------
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      off_run[c]   = (off_st_q[c] == OFF_RUN);
      trig_hold[c] = (led_st_q[c] == LED_EVAL) & led_trig_ch_q[c];
    end
    drive_d = ((out_on_cmd_i & ~trig_hold) | off_run) & ~fault_sd_q; // RULE4 RULE17
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      out_drive_q <= '0;
      off_lim_q   <= '0;
      csb_q       <= 1'b1;
    end else begin
      out_drive_q <= drive_d;
      off_lim_q   <= off_run & ~fault_sd_q; // RULE17 RULE20
      csb_q       <= spi_chip_select_n_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fault_sd_q <= '0;
      for (int c = 0; c < NCH; c++) flt_cnt_q[c] <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (overtemp_shutdown_i[c] | undervoltage_fault_i | charge_pump_fault_i) begin
          if (flt_cnt_q[c] == FAULT_SD_CYC - 16'h0001) begin
            fault_sd_q[c] <= 1'b1; // RULE22
          end else begin
            flt_cnt_q[c] <= flt_cnt_q[c] + 16'h0001;
          end
        end else begin
          flt_cnt_q[c]  <= '0;
          fault_sd_q[c] <= 1'b0;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // standard on-state openload
  // ------------------------------------------------------------------
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      std_cond[c] = out_drive_q[c] & ~led_en_q[c] & ~off_run[c] & on_current_low_i[c]; // RULE1 RULE7
      std_set[c]  = std_cond[c] & (on_cnt_q[c] == dgl_limit(dgl_sel_q[c]) - 16'h0001);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (int c = 0; c < NCH; c++) on_cnt_q[c] <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (!std_cond[c]) begin
          on_cnt_q[c] <= '0; // RULE6
        end else if (!std_set[c]) begin
          on_cnt_q[c] <= on_cnt_q[c] + 16'h0001; // RULE25
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // LED low-current detection
  // ------------------------------------------------------------------
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      led_set[c]   = (led_st_q[c] == LED_EVAL) & led_out_high_i[c]
                     & ((led_cnt_q[c] == LED_WIN_CYC - 16'h0001)
                        | (~led_trig_ch_q[c] & drive_d[c] & ~out_drive_q[c])); // RULE8
      trig_done[c] = (led_st_q[c] == LED_IDLE) & (trig_seen_q[c] | ~led_en_q[c] | ~out_on_cmd_i[c]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      trig_q <= 1'b0;
    end else if (wr_done && avs_address_i == ADDR_CTRL && avs_byteenable_i[1]) begin
      trig_q <= avs_writedata_i[CTRL_TRIG_BIT]; // RULE11
    end else if (trig_q & (&trig_done)) begin
      trig_q <= 1'b0; // RULE12
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      led_trig_ch_q <= '0;
      trig_seen_q   <= '0;
      led_cur_q     <= '0;
      for (int c = 0; c < NCH; c++) begin
        led_st_q[c]  <= LED_IDLE;
        led_cnt_q[c] <= '0;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (wr_done && avs_address_i == ADDR_CTRL && avs_byteenable_i[1]) trig_seen_q[c] <= 1'b0;
        case (led_st_q[c])
          LED_IDLE: begin
            led_cnt_q[c] <= '0;
            if (led_en_q[c] & trig_q & ~trig_seen_q[c] & out_drive_q[c] & out_on_cmd_i[c]) begin
              led_st_q[c]      <= LED_EVAL; // RULE11
              led_trig_ch_q[c] <= 1'b1;
              trig_seen_q[c]   <= 1'b1;
              led_cur_q[c]     <= 1'b1;
            end else if (led_en_q[c] & out_drive_q[c] & ~drive_d[c] & ~off_run[c]) begin
              led_st_q[c]      <= LED_EVAL; // RULE8 RULE9
              led_trig_ch_q[c] <= 1'b0;
              led_cur_q[c]     <= 1'b1;
            end
          end
          LED_EVAL: begin
            led_cnt_q[c] <= led_cnt_q[c] + 16'h0001;
            if (!led_out_high_i[c] || led_set[c]) begin
              led_cnt_q[c] <= '0;
              if (led_trig_ch_q[c]) begin
                led_st_q[c] <= LED_TAIL; // RULE13
              end else begin
                led_st_q[c]  <= LED_IDLE; // RULE10
                led_cur_q[c] <= 1'b0;
              end
            end
          end
          LED_TAIL: begin
            led_cnt_q[c] <= led_cnt_q[c] + 16'h0001;
            if (led_cnt_q[c] == LED_TAIL_CYC - 16'h0001) begin
              led_st_q[c]      <= LED_IDLE; // RULE11
              led_trig_ch_q[c] <= 1'b0;
              led_cur_q[c]     <= 1'b0;
            end
          end
          default: begin
            led_st_q[c]  <= LED_IDLE;
            led_cur_q[c] <= 1'b0;
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // off-state openload test
  // ------------------------------------------------------------------
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      off_set[c] = off_run[c] & ~fault_sd_q[c] & ~off_test_current_reached_i[c]
                   & (off_cnt_q[c] == OFF_TIMEOUT_CYC - 16'h0001); // RULE18 RULE19
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (int c = 0; c < NCH; c++) begin
        off_st_q[c]  <= OFF_IDLE; // RULE15
        off_cnt_q[c] <= '0;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        case (off_st_q[c])
          OFF_IDLE, OFF_ARMED: begin
            off_cnt_q[c] <= '0;
            if (wr_done && avs_address_i == ADDR_OFF_TEST && avs_byteenable_i[0]) begin
              off_st_q[c] <= avs_writedata_i[c] ? OFF_ARMED : OFF_IDLE; // RULE15
            end else if (off_st_q[c] == OFF_ARMED && csb_rise) begin
              off_st_q[c] <= OFF_RUN; // RULE16
            end
          end
          OFF_RUN: begin
            off_cnt_q[c] <= off_cnt_q[c] + 16'h0001;
            if (fault_sd_q[c] | off_test_current_reached_i[c] | off_set[c]) begin
              off_st_q[c] <= OFF_IDLE; // RULE18 RULE22
            end
          end
          default: off_st_q[c] <= OFF_IDLE;
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // latched flags, set wins over clear
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      on_ol_q  <= '0;
      off_ol_q <= '0;
      quick_q  <= '0;
      global_q <= 1'b0;
    end else begin
      on_ol_q  <= (on_ol_q & ~clr_on) | std_set | led_set; // RULE2 RULE3
      off_ol_q <= (off_ol_q & ~clr_off) | off_set; // RULE21
      quick_q  <= on_ol_q | off_ol_q | ch_other_fault_i; // RULE23
      global_q <= |(on_ol_q | off_ol_q); // RULE24
    end
  end

  assign avs_readdata_o           = rdata_q;
  assign avs_waitrequest_o        = wait_q;
  assign out_drive_o              = out_drive_q;
  assign led_test_current_o       = led_cur_q;
  assign off_test_current_limit_o = off_lim_q;
  assign channel_quick_flag_o     = quick_q;
  assign global_openload_flag_o   = global_q;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence off_timeout_s;
    off_run[2] ##0 off_set[2];
  endsequence

  on_stays_on_a: assert property (out_on_cmd_i[0] & ~trig_hold[0] & ~fault_sd_q[0] |=> out_drive_q[0]) // RULE4
    else $error("output dropped while commanded on");
  dgl_limit_a: assert property ($rose(on_ol_q[0]) & ~$past(led_set[0])
      |-> $past(on_cnt_q[0]) == dgl_limit($past(dgl_sel_q[0])) - 16'h0001) // RULE5
    else $error("on-state flag set before deglitch count");
  dgl_clear_a: assert property (~out_drive_q[0] |=> on_cnt_q[0] == '0) // RULE6
    else $error("deglitch counter not cleared with output low");
  set_wins_a: assert property (std_set[0] | led_set[0] |=> on_ol_q[0]) // RULE3
    else $error("on-state flag set lost");
  off_start_a: assert property (off_st_q[0] == OFF_ARMED & csb_rise & ~wr_done |=> off_st_q[0] == OFF_RUN) // RULE16
    else $error("off test did not start on chip select edge");
  off_flag_a: assert property (off_timeout_s |=> off_ol_q[2] & off_st_q[2] == OFF_IDLE
      ##1 (~out_drive_q[2] | $past(out_on_cmd_i[2]))) // RULE18
    else $error("off test timeout not latched");
  off_quiet_a: assert property (off_run[3] & off_test_current_reached_i[3] & ~off_set[3]
      & ~$past(off_set[3]) |=> off_st_q[3] == OFF_IDLE & ~$rose(off_ol_q[3])) // RULE18
    else $error("off test reported despite reaching threshold");
  off_hold_a: assert property (off_run[2] & ~fault_sd_q[2] & ~off_test_current_reached_i[2]
      & off_cnt_q[2] < OFF_TIMEOUT_CYC - 16'h0001 |=> off_run[2]) // RULE15 RULE19
    else $error("off test ended early");
  fault_abort_a: assert property (fault_sd_q[2] |=> off_st_q[2] != OFF_RUN ##0 ~out_drive_q[2]) // RULE22
    else $error("fault did not abort off test");
  led_stop_a: assert property (led_st_q[1] == LED_EVAL & ~led_out_high_i[1] & ~led_trig_ch_q[1]
      |=> ~led_test_current_o[1]) // RULE10
    else $error("led test current not stopped");
  trig_clear_a: assert property ($fell(trig_q) & ~$past(wr_done) |-> $past(led_st_q[0]) == LED_IDLE) // RULE12
    else $error("trigger cleared during evaluation");
  quick_or_a: assert property (##1 quick_q == $past(on_ol_q | off_ol_q | ch_other_fault_i)) // RULE23
    else $error("quick flag mismatch");

endmodule

// ### oldiag_pkg.sv
/*
  Constants and types for the per-channel openload diagnostic block.
  Assumes a 10 MHz core clock and a 32-bit Avalon-MM register port.
*/
package oldiag_pkg;

  // ------------------------------------------------------------------
  // sizes and timing
  // ------------------------------------------------------------------
  localparam int          NCH             = 4;
  localparam int          CNT_W           = 16;
  localparam int          ADDR_W          = 5;
  localparam int          CLK_PERIOD_NS   = 100;
  localparam int          ON_DGL_SHORT_NS = 64000;
  localparam int          ON_DGL_LONG_NS  = 2000000;
  localparam int          LED_WIN_NS      = 2000000;
  localparam int          LED_TAIL_NS     = 100000;
  localparam int          OFF_TIMEOUT_NS  = 1200000;
  localparam int          FAULT_SD_NS     = 3300;
  localparam logic [15:0] ON_DGL_SHORT_CYC    = 16'(ON_DGL_SHORT_NS / CLK_PERIOD_NS);
  localparam logic [15:0] ON_DGL_LONG_CYC_DEF = 16'(ON_DGL_LONG_NS / CLK_PERIOD_NS);
  localparam logic [15:0] LED_WIN_CYC_DEF     = 16'(LED_WIN_NS / CLK_PERIOD_NS);
  localparam logic [15:0] LED_TAIL_CYC        = 16'(LED_TAIL_NS / CLK_PERIOD_NS);
  localparam logic [15:0] OFF_TIMEOUT_CYC_DEF = 16'(OFF_TIMEOUT_NS / CLK_PERIOD_NS);
  localparam logic [15:0] FAULT_SD_CYC        = 16'(FAULT_SD_NS / CLK_PERIOD_NS);

  // ------------------------------------------------------------------
  // register map and fields
  // ------------------------------------------------------------------
  localparam logic [4:0]  ADDR_CTRL     = 5'h00;
  localparam logic [4:0]  ADDR_OFF_TEST = 5'h04;
  localparam logic [4:0]  ADDR_QUICK    = 5'h08;
  localparam logic [4:0]  ADDR_CH_BASE  = 5'h0c;
  localparam logic [4:0]  ADDR_CH_STEP  = 5'h04;
  localparam int          CTRL_DGL_LSB  = 0;
  localparam int          CTRL_LED_LSB  = 4;
  localparam int          CTRL_TRIG_BIT = 8;
  localparam int          CH_OFF_BIT    = 0;
  localparam int          CH_ON_BIT     = 1;
  localparam int          GLOBAL_BIT    = 8;
  localparam logic [3:0]  DGL_SEL_RST   = 4'h0;
  localparam logic [3:0]  LED_EN_RST    = 4'h0;

  // ------------------------------------------------------------------
  // state types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {LED_IDLE = 2'b00, LED_EVAL = 2'b01, LED_TAIL = 2'b11} oldiag_led_st_t;
  typedef enum logic [1:0] {OFF_IDLE = 2'b00, OFF_ARMED = 2'b01, OFF_RUN = 2'b11} oldiag_off_st_t;

endpackage

// ### oldiag_load_model.sv
/*
  Comparator model for four switched loads, open or present per channel.
  Assumes drive and test-current levels come from the diagnostics block.
*/
`timescale 1ns/100ps
module oldiag_load_model (
  input  wire logic       clk_i,
  input  wire logic [3:0] load_open_i,
  input  wire logic [3:0] out_drive_i,
  input  wire logic [3:0] led_current_i,
  input  wire logic [3:0] limit_i,
  output logic      [3:0] current_low_o,
  output logic      [3:0] out_high_o,
  output logic      [3:0] reached_o
);
  // ------------------------------------------------------------------
  // comparators
  // ------------------------------------------------------------------
  logic [3:0] drive_q;
  assign current_low_o = ~out_drive_i | load_open_i;
  // output falls over two cycles; an open one is held up by test current
  always_ff @(posedge clk_i) begin
    drive_q    <= out_drive_i;
    out_high_o <= out_drive_i | drive_q | (led_current_i & load_open_i);
    reached_o  <= limit_i & out_drive_i & ~load_open_i;
  end
endmodule

// ### oldiag_top_tb.sv
/*
  Self-checking bench for oldiag_top driven through its register port.
  Assumes the register map and bus timing of the design package.
*/
`timescale 1ns/100ps
module oldiag_top_tb;
  import oldiag_pkg::*;
  // ------------------------------------------------------------------
  // signals and instances
  // ------------------------------------------------------------------
  logic        clk_i = 0, rst_n_i = 0, rd = 0, wr = 0, spi_chip_select_n = 1, uv = 0, charge_pump_fault = 0, wait_o, gf;
  logic [4:0]  addr = 5'h00;
  logic [31:0] wd = 32'h0, rdata;
  logic [3:0]  cmd = 4'h0, open = 4'h0, oth = 4'h0, overtemp_shutdown = 4'h0, drv, ledc, lim, cl, oh, rch, qf;
  int          n_fail = 0, compares = 0, cyc = 0;
  oldiag_top #(.ON_DGL_LONG_CYC(16'h0028), .LED_WIN_CYC(16'h0028), .OFF_TIMEOUT_CYC(16'h0064)) dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(4'hf), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o),
    .out_on_cmd_i(cmd), .on_current_low_i(cl), .led_out_high_i(oh), .off_test_current_reached_i(rch),
    .ch_other_fault_i(oth), .overtemp_shutdown_i(overtemp_shutdown), .undervoltage_fault_i(uv),
    .charge_pump_fault_i(charge_pump_fault), .spi_chip_select_n_i(spi_chip_select_n), .out_drive_o(drv), .led_test_current_o(ledc),
    .off_test_current_limit_o(lim), .channel_quick_flag_o(qf), .global_openload_flag_o(gf));
  oldiag_load_model load (.clk_i(clk_i), .load_open_i(open), .out_drive_i(drv), .led_current_i(ledc),
    .limit_i(lim), .current_low_o(cl), .out_high_o(oh), .reached_o(rch));
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      give_verdict();
    end
  end
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic give_verdict();
    if (n_fail == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [31:0] exp);
    @(posedge clk_i);
    addr <= a; wd <= d; wr <= w; rd <= !w;
    do @(posedge clk_i); while (wait_o !== 1'b0);
    if (!w) chk(rdata, exp);
    wr <= 1'b0; rd <= 1'b0;
  endtask
  function automatic logic [4:0] chs(input int c);
    return ADDR_CH_BASE + 5'(c) * ADDR_CH_STEP;
  endfunction
  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    bus(1'b0, ADDR_CTRL, 32'h0, 32'h0);
    bus(1'b0, ADDR_OFF_TEST, 32'h0, 32'h0);
    bus(1'b0, 5'h1c, 32'h0, 32'h0);
    oth <= 4'h8; tick(3);
    chk(32'({gf, qf}), 32'h8);
    oth <= 4'h0;
  endtask
  task automatic t_on_short();
    open <= 4'h1; cmd <= 4'h1; tick(600);
    chk(32'(qf), 32'h0);
    tick(100);
    chk(32'({gf, drv, qf}), 32'h111);
    bus(1'b0, chs(0), 32'h0, 32'h102);
    bus(1'b0, chs(0), 32'h0, 32'h102);
    open <= 4'h0; tick(2);
    bus(1'b0, chs(0), 32'h0, 32'h102);
    bus(1'b0, chs(0), 32'h0, 32'h0);
    tick(3);
    chk(32'(gf), 32'h0);
    cmd <= 4'h0;
  endtask
  task automatic t_on_long();
    bus(1'b1, ADDR_CTRL, 32'h2, 32'h0);
    open <= 4'h2; cmd <= 4'h2; tick(30);
    cmd <= 4'h0; tick(2);
    cmd <= 4'h2; tick(30);
    chk(32'(qf), 32'h0);
    tick(30);
    chk(32'(qf), 32'h2);
    open <= 4'h0; tick(2);
    bus(1'b0, chs(1), 32'h0, 32'h102);
    bus(1'b0, chs(1), 32'h0, 32'h0);
    cmd <= 4'h0;
  endtask
  task automatic t_off();
    open <= 4'h4;
    bus(1'b1, ADDR_OFF_TEST, 32'hc, 32'h0);
    bus(1'b0, ADDR_OFF_TEST, 32'h0, 32'hc);
    tick(5);
    chk(32'(drv), 32'h0);
    spi_chip_select_n <= 1'b0; tick(1);
    spi_chip_select_n <= 1'b1; tick(3);
    chk(32'({lim[2], drv[2]}), 32'h3);
    bus(1'b1, ADDR_OFF_TEST, 32'h0, 32'h0);
    bus(1'b0, ADDR_OFF_TEST, 32'h0, 32'h4);
    tick(80);
    chk(32'(drv), 32'h4);
    tick(30);
    chk(32'({qf, drv}), 32'h40);
    bus(1'b0, ADDR_OFF_TEST, 32'h0, 32'h0);
    bus(1'b0, chs(3), 32'h0, 32'h100);
    bus(1'b0, chs(2), 32'h0, 32'h101);
    bus(1'b0, chs(2), 32'h0, 32'h0);
  endtask
  task automatic t_fault();
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, ADDR_OFF_TEST, 32'h4, 32'h0);
      spi_chip_select_n <= 1'b0; tick(1);
      spi_chip_select_n <= 1'b1; tick(3);
      uv <= (k == 0); overtemp_shutdown <= (k == 1) ? 4'h4 : 4'h0; charge_pump_fault <= (k == 2); tick(20);
      chk(32'(drv), 32'h4);
      tick(20);
      chk(32'(drv), 32'h0);
      uv <= 1'b0; overtemp_shutdown <= 4'h0; charge_pump_fault <= 1'b0; tick(100);
      bus(1'b0, chs(2), 32'h0, 32'h0);
    end
  endtask
  task automatic t_led();
    bus(1'b1, ADDR_CTRL, 32'h30, 32'h0);
    open <= 4'h1; cmd <= 4'h3; tick(10);
    cmd <= 4'h0; tick(8);
    chk(32'(ledc), 32'h1);
    tick(60);
    chk(32'({qf, ledc}), 32'h10);
    bus(1'b0, chs(0), 32'h0, 32'h102);
    bus(1'b0, chs(0), 32'h0, 32'h0);
    cmd <= 4'h1; tick(10);
    cmd <= 4'h0; tick(10);
    cmd <= 4'h1; tick(4);
    chk(32'(qf), 32'h1);
    bus(1'b0, chs(0), 32'h0, 32'h102);
  endtask
  task automatic t_trig();
    bus(1'b1, ADDR_CTRL, 32'h110, 32'h0);
    tick(500);
    chk(32'({qf, ledc}), 32'h11);
    tick(700);
    chk(32'(ledc), 32'h0);
    bus(1'b0, ADDR_CTRL, 32'h0, 32'h10);
    cmd <= 4'h0; open <= 4'h0;
  endtask
  initial begin
    tick(20);
    rst_n_i <= 1'b1;
    t_reset();
    t_on_short();
    t_on_long();
    t_off();
    t_fault();
    t_led();
    t_trig();
    give_verdict();
  end
endmodule
